// file: design/sensor_dsp_readout_diag.v
// What this block does
// RULE_01: set lock forbids all later parameter programming
// RULE_02: pin command triggers access, digital reply, analog off
// RULE_03: device is selected only through its own pin
// RULE_04: snapshots read-only, parameters writable, steer processing
// RULE_05: temperature reading is signed 16-bit word
// RULE_06: raw field after range select, uncompensated, signed
// RULE_07: factory-compensated field as signed 16-bit word
// RULE_08: customer gain quadratic, offset linear in temperature
// RULE_09: linearized field after sixteen-point stage
// RULE_10: scaled output field after output gain/offset
// RULE_11: final output word also drives converter
// RULE_12: two production info words, read-only
// RULE_13: self-test status, bits 15:6 and 1:0 reserved
// RULE_14: bit 5 flags state-machine self-test failure
// RULE_15: bit 4 flags power-up memory self-test failure
// RULE_16: bit 3 flags program-memory parity error
// RULE_17: bit 2 flags factory compensation overflow
// RULE_18: programmer verifies each write by status/second ack
// RULE_19: prog status bit 10 low programming voltage
// RULE_20: prog status bit 9 low supply during program
// RULE_21: prog status bit 8 setup storage write failed
// RULE_22: prog status bits 7:0 carry programming details
// RULE_23: raw field saturates instead of wrapping
// RULE_24: 3-bit setup field picks 16 of 22 bits
// RULE_25: error flags sticky until power-up, reads harmless
// RULE_26: snapshots update together once per cycle
`timescale 1ns/10ps
`include "sensor_readout_map.vh"

module sensor_dsp_readout_diag #(
  parameter [15:0] PROD_INFO_A = 16'h1234, // arbitrary value
  parameter [15:0] PROD_INFO_B = 16'h5678  // arbitrary value
) (
  input wire clk_sys,
  input wire rst_b,
  input wire pin_in,
  output wire pin_out,
  output reg pin_oe,
  output reg analog_enable,
  output wire [15:0] dac_word,
  input wire sample_valid,
  input wire [15:0] temperature_in,
  input wire [21:0] decimated_field_in,
  input wire [15:0] factory_field_in,
  input wire factory_overflow_in,
  input wire [15:0] linearized_in,
  input wire [15:0] scaled_in,
  input wire [15:0] final_in,
  input wire fsm_selftest_fail,
  input wire nvm_selftest_done,
  input wire nvm_selftest_fail,
  input wire rom_parity_error,
  input wire nvm_lock_stored,
  output reg nvm_prog_start,
  output reg [2:0] nvm_prog_index,
  output reg [15:0] nvm_prog_data,
  input wire nvm_prog_done,
  input wire nvm_pump_low,
  input wire nvm_supply_low,
  input wire nvm_write_fail,
  input wire [7:0] nvm_prog_result,
  output wire [15:0] setup_word,
  output wire [15:0] gain_coeff_const,
  output wire [15:0] gain_coeff_linear,
  output wire [15:0] gain_coeff_square,
  output wire [15:0] offset_coeff_const,
  output wire [15:0] offset_coeff_linear
);

  localparam integer BIT_CYCLES =
    (`BIT_TIME_NS * `CLK_FREQ_KHZ) / 1000000;
  localparam integer HALF_CYCLES = BIT_CYCLES / 2;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_RECV = 3'h2;
  localparam [2:0] ST_EXEC = 3'h3;
  localparam [2:0] ST_REPLY = 3'h4;
  localparam [2:0] ST_PROG = 3'h5;

  reg [15:0] snap [0:6];
  reg [15:0] param [0:5];
  reg self_fsm, self_nvm, self_rom, self_ovf;
  reg prog_pump, prog_supply, prog_nvram;
  reg [7:0] prog_detail;
  reg line_s1, line_s2, line_prev;
  reg [2:0] state;
  reg [7:0] tmr;
  reg [4:0] bit_cnt;
  reg [4:0] tx_len;
  reg [`CMD_BITS-1:0] rx_shift;
  reg [16:0] tx_shift;
  reg then_prog;
  reg [15:0] read_data;
  reg commit;

  wire locked = param[0][`SETUP_LOCK_BIT];
  wire cmd_write = rx_shift[`CMD_WRITE_BIT];
  wire [6:0] cmd_addr = rx_shift[`CMD_ADDR_HI:`CMD_ADDR_LO];
  wire [15:0] cmd_data = rx_shift[15:0];
  wire [6:0] param_off = cmd_addr - `IDX_PARAM_BASE;
  wire is_param = (cmd_addr >= `IDX_PARAM_BASE) &&
                  (cmd_addr <= `IDX_PARAM_LAST);
  wire bit_end = (tmr == BIT_CYCLES - 1);

  assign pin_out = tx_shift[16];
  assign dac_word = snap[6]; // [RULE_11]
  assign setup_word = param[0];
  assign gain_coeff_const = param[1];
  assign gain_coeff_linear = param[2];
  assign gain_coeff_square = param[3];
  assign offset_coeff_const = param[4];
  assign offset_coeff_linear = param[5];

  // range window: setting n keeps bits 22-n down to 7-n
  wire [2:0] range_sel = param[0][`SETUP_RANGE_HI:`SETUP_RANGE_LO];
  wire [2:0] shift_lo = 3'h7 - range_sel; // [RULE_24]
  wire signed [21:0] decim_s = decimated_field_in;
  wire signed [21:0] shifted = decim_s >>> shift_lo;
  wire fits = (shifted[21:15] == {7{shifted[15]}});
  // clamp rather than wrap so sign survives an over-range field
  wire [15:0] raw_field = fits ? shifted[15:0] :
    (shifted[21] ? 16'h8000 : 16'h7FFF); // [RULE_23] [RULE_06]

  // customer compensation in Q15: gain quadratic, offset linear in temp
  wire signed [15:0] tmp = temperature_in;
  wire signed [15:0] fac = factory_field_in;
  wire signed [15:0] gc0 = param[1];
  wire signed [15:0] gc1 = param[2];
  wire signed [15:0] gc2 = param[3];
  wire signed [15:0] oc0 = param[4];
  wire signed [15:0] oc1 = param[5];
  wire signed [31:0] t_sq = tmp * tmp;
  wire signed [15:0] t_sq_q = t_sq[30] ? 16'h7FFF : t_sq[30:15];
  wire signed [31:0] g1_p = gc1 * tmp;
  wire signed [31:0] g2_p = gc2 * t_sq_q;
  wire signed [31:0] o1_p = oc1 * tmp;
  wire signed [17:0] g0_x = {{2{gc0[15]}}, gc0};
  wire signed [17:0] g1_x = {g1_p[31], g1_p[31:15]};
  wire signed [17:0] g2_x = {g2_p[31], g2_p[31:15]};
  wire signed [17:0] gain = g0_x + g1_x + g2_x; // [RULE_08]
  wire signed [17:0] o0_x = {{2{oc0[15]}}, oc0};
  wire signed [17:0] o1_x = {o1_p[31], o1_p[31:15]};
  wire signed [17:0] offs = o0_x + o1_x; // [RULE_08]
  wire signed [33:0] fg = fac * gain;
  wire signed [19:0] fg_x = {fg[33], fg[33:15]}; // keep sign of product
  wire signed [19:0] offs_x = {{2{offs[17]}}, offs};
  wire signed [19:0] cust_sum = fg_x + offs_x;
  wire cust_fits = (cust_sum[19:15] == {5{cust_sum[15]}});
  wire [15:0] cust_field = cust_fits ? cust_sum[15:0] :
    (cust_sum[19] ? 16'h8000 : 16'h7FFF);

  // pin synchroniser; only line_s2 and later stages feed logic
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      line_s1 <= 1'b1;
      line_s2 <= 1'b1;
      line_prev <= 1'b1;
    end else begin
      line_s1 <= pin_in;
      line_s2 <= line_s1;
      line_prev <= line_s2;
    end
  end

  // all snapshots load on the same strobe, never piecemeal
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      snap[0] <= `SNAP_RESET;
      snap[1] <= `SNAP_RESET;
      snap[2] <= `SNAP_RESET;
      snap[3] <= `SNAP_RESET;
      snap[4] <= `SNAP_RESET;
      snap[5] <= `SNAP_RESET;
      snap[6] <= `SNAP_RESET;
    end else if (sample_valid) begin // [RULE_26]
      snap[0] <= temperature_in; // [RULE_05]
      snap[1] <= raw_field; // [RULE_06]
      snap[2] <= factory_field_in; // [RULE_07]
      snap[3] <= cust_field; // [RULE_08]
      snap[4] <= linearized_in; // [RULE_09]
      snap[5] <= scaled_in; // [RULE_10]
      snap[6] <= final_in; // [RULE_11]
    end
  end

  // parameter storage, one entry per index; lock bit only ever sets
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_param
      always @(posedge clk_sys) begin
        if (!rst_b) begin
          param[gi] <= (gi == 0) ? `SETUP_RESET :
                       (gi == 1) ? `GAIN_CONST_RESET : `COEFF_RESET;
        end else if (commit && nvm_prog_index == gi) begin // [RULE_04]
          if (gi == 0) begin
            param[gi] <= nvm_prog_data | (param[gi] & 16'h0001); // [RULE_01]
          end else begin
            param[gi] <= nvm_prog_data;
          end
        end else if (gi == 0 && nvm_lock_stored) begin
          param[gi] <= param[gi] | 16'h0001; // [RULE_01]
        end
      end
    end
  endgenerate

  // sticky error flags, cleared only by power-up reset
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      self_fsm <= 1'b0;
      self_nvm <= 1'b0;
      self_rom <= 1'b0;
      self_ovf <= 1'b0;
      prog_pump <= 1'b0;
      prog_supply <= 1'b0;
      prog_nvram <= 1'b0;
      prog_detail <= 8'h00;
    end else begin
      if (fsm_selftest_fail)
        self_fsm <= 1'b1; // [RULE_14] [RULE_25]
      if (nvm_selftest_done && nvm_selftest_fail)
        self_nvm <= 1'b1; // [RULE_15]
      if (rom_parity_error)
        self_rom <= 1'b1; // [RULE_16]
      if (sample_valid && factory_overflow_in)
        self_ovf <= 1'b1; // [RULE_17]
      if (state == ST_PROG && nvm_prog_done) begin
        if (nvm_pump_low)
          prog_pump <= 1'b1; // [RULE_19]
        if (nvm_supply_low)
          prog_supply <= 1'b1; // [RULE_20]
        if (nvm_write_fail)
          prog_nvram <= 1'b1; // [RULE_21]
        prog_detail <= nvm_prog_result; // [RULE_22]
      end
    end
  end

  // read mux; reserved bits return zero and reading changes nothing
  always @* begin
    case (cmd_addr)
      `IDX_TEMPERATURE: read_data = snap[0];
      `IDX_RAW_FIELD: read_data = snap[1];
      `IDX_FACTORY_COMP: read_data = snap[2];
      `IDX_CUSTOMER_COMP: read_data = snap[3];
      `IDX_LINEARIZED: read_data = snap[4];
      `IDX_SCALED_OUT: read_data = snap[5];
      `IDX_CONVERTER_WORD: read_data = snap[6];
      `IDX_PROD_INFO_A: read_data = PROD_INFO_A; // [RULE_12]
      `IDX_PROD_INFO_B: read_data = PROD_INFO_B; // [RULE_12]
      `IDX_SELF_TEST: read_data = {10'h000, self_fsm, self_nvm,
        self_rom, self_ovf, 2'h0}; // [RULE_13] [RULE_25]
      `IDX_PROG_STATUS: read_data = {5'h00, prog_pump, prog_supply,
        prog_nvram, prog_detail};
      default: read_data = is_param ? param[param_off[2:0]] : 16'h0000;
    endcase
  end

  // link engine: each device hears only frames on its own pin, so
  // no address of the device itself is carried in the frame
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      tmr <= 8'h00;
      bit_cnt <= 5'h00;
      tx_len <= 5'h00;
      rx_shift <= {`CMD_BITS{1'b0}};
      tx_shift <= 17'h1FFFF;
      then_prog <= 1'b0;
      pin_oe <= 1'b0;
      analog_enable <= 1'b1;
      nvm_prog_start <= 1'b0;
      nvm_prog_index <= 3'h0;
      nvm_prog_data <= 16'h0000;
      commit <= 1'b0;
    end else begin
      nvm_prog_start <= 1'b0;
      commit <= 1'b0;
      tmr <= tmr + 8'h01;
      case (state)
        ST_IDLE: begin
          tmr <= 8'h00;
          if (line_prev && !line_s2) begin // [RULE_03]
            state <= ST_START;
            analog_enable <= 1'b0; // [RULE_02]
          end
        end
        ST_START: begin
          // recheck at mid-bit so a short glitch is dropped
          if (tmr == HALF_CYCLES - 1) begin
            tmr <= 8'h00;
            bit_cnt <= 5'h00;
            if (line_s2) begin
              state <= ST_IDLE;
              analog_enable <= 1'b1;
            end else begin
              state <= ST_RECV;
            end
          end
        end
        ST_RECV: begin
          if (bit_end) begin
            tmr <= 8'h00;
            rx_shift <= {rx_shift[`CMD_BITS-2:0], line_s2};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `CMD_BITS - 1)
              state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          tmr <= 8'h00;
          bit_cnt <= 5'h00;
          state <= ST_REPLY;
          pin_oe <= 1'b1; // [RULE_02]
          if (!cmd_write) begin
            tx_shift <= {1'b0, read_data};
            tx_len <= `READ_REPLY_BITS;
            then_prog <= 1'b0;
          end else if (is_param && !locked) begin
            tx_shift <= {2'b01, 15'h7FFF};
            tx_len <= `ACK_REPLY_BITS;
            then_prog <= 1'b1;
            nvm_prog_index <= param_off[2:0];
            nvm_prog_data <= cmd_data;
          end else begin
            // refused: first ack, then a failing second ack at once
            tx_shift <= {4'h4, 13'h1FFF}; // [RULE_01] [RULE_04]
            tx_len <= `REFUSE_REPLY_BITS;
            then_prog <= 1'b0;
          end
        end
        ST_REPLY: begin
          if (bit_end) begin
            tmr <= 8'h00;
            tx_shift <= {tx_shift[15:0], 1'b1};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == tx_len - 5'h01) begin
              pin_oe <= 1'b0;
              tx_shift <= 17'h1FFFF;
              if (then_prog) begin
                state <= ST_PROG;
                nvm_prog_start <= 1'b1;
              end else begin
                state <= ST_IDLE;
                analog_enable <= 1'b1;
              end
            end
          end
        end
        ST_PROG: begin
          tmr <= 8'h00;
          bit_cnt <= 5'h00;
          if (nvm_prog_done) begin
            // second ack tells the programmer whether storage took
            commit <= !(nvm_pump_low | nvm_supply_low | nvm_write_fail);
            tx_shift <= {1'b0, !(nvm_pump_low | nvm_supply_low |
              nvm_write_fail), 15'h7FFF}; // [RULE_18]
            tx_len <= `ACK_REPLY_BITS;
            then_prog <= 1'b0;
            pin_oe <= 1'b1;
            state <= ST_REPLY;
          end
        end
        default: begin
          state <= ST_IDLE;
          pin_oe <= 1'b0;
          analog_enable <= 1'b1;
        end
      endcase
    end
  end

endmodule // sensor_dsp_readout_diag

// file: design/sensor_readout_map.vh
`ifndef SENSOR_READOUT_MAP_VH
`define SENSOR_READOUT_MAP_VH

// register indices on the pin link (7-bit address field)
`define IDX_TEMPERATURE 7'h00
`define IDX_RAW_FIELD 7'h01
`define IDX_FACTORY_COMP 7'h02
`define IDX_CUSTOMER_COMP 7'h03
`define IDX_LINEARIZED 7'h04
`define IDX_SCALED_OUT 7'h05
`define IDX_CONVERTER_WORD 7'h06
`define IDX_PROD_INFO_A 7'h07
`define IDX_PROD_INFO_B 7'h08
`define IDX_SELF_TEST 7'h09
`define IDX_PROG_STATUS 7'h0A
// writable parameters: setup, then five coefficients
`define IDX_PARAM_BASE 7'h10
`define IDX_PARAM_LAST 7'h15

// self-test status bit positions
`define SELF_FSM_BIT 5
`define SELF_NVM_BIT 4
`define SELF_ROM_BIT 3
`define SELF_OVF_BIT 2

// programming status bit positions
`define PROG_PUMP_BIT 10
`define PROG_SUPPLY_BIT 9
`define PROG_NVRAM_BIT 8

// setup word fields
`define SETUP_LOCK_BIT 0
`define SETUP_RANGE_HI 14
`define SETUP_RANGE_LO 12

// reset values
`define SETUP_RESET 16'h1000
`define GAIN_CONST_RESET 16'h7FFF
`define COEFF_RESET 16'h0000
`define SNAP_RESET 16'h0000

// command frame layout
`define CMD_BITS 24
`define CMD_WRITE_BIT 23
`define CMD_ADDR_HI 22
`define CMD_ADDR_LO 16
`define READ_REPLY_BITS 5'h11
`define ACK_REPLY_BITS 5'h02
`define REFUSE_REPLY_BITS 5'h04

// link timing
`define CLK_FREQ_KHZ 10000
`define BIT_TIME_NS 10000

`endif

// file: tb/sensor_readout_sva.sv
`timescale 1ns/10ps
// watches the pin link, the converter word and the parameter file
module sensor_readout_sva (
  input wire clk_sys,
  input wire rst_b,
  input wire pin_in,
  input wire pin_out,
  input wire pin_oe,
  input wire analog_enable,
  input wire [15:0] dac_word,
  input wire sample_valid,
  input wire [15:0] final_in,
  input wire nvm_prog_start,
  input wire [2:0] nvm_prog_index,
  input wire nvm_prog_done,
  input wire [15:0] setup_word,
  input wire [15:0] offset_coeff_const
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_dac_capture: assert property (
    sample_valid |=> dac_word == $past(final_in))
    else $error("converter word missed a sample");
  chk_dac_hold: assert property (
    !sample_valid |=> $stable(dac_word))
    else $error("converter word moved without a sample");
  chk_analog_off: assert property (
    pin_oe |-> !analog_enable)
    else $error("analog output on while replying");
  // a start edge in idle must silence the analog driver quickly
  chk_frame_start: assert property (
    $fell(pin_in) && !pin_oe && analog_enable |-> ##[1:4] !analog_enable)
    else $error("frame start not taken");
  chk_start_bit: assert property (
    $rose(pin_oe) |-> !pin_out [*8])
    else $error("reply start bit missing");
  chk_lock_blocks: assert property (
    nvm_prog_start |-> !setup_word[0])
    else $error("programming while locked");
  chk_lock_sticky: assert property (
    setup_word[0] |=> setup_word[0])
    else $error("lock flag cleared");
  chk_param_index: assert property (
    nvm_prog_start |-> nvm_prog_index <= 3'h5)
    else $error("program index outside parameters");
  chk_setup_write: assert property (
    $changed(setup_word) |-> $past(nvm_prog_done, 2))
    else $error("setup changed without storage");
  chk_offset_write: assert property (
    $changed(offset_coeff_const) |-> $past(nvm_prog_done, 2))
    else $error("offset changed without storage");

  cover property (nvm_prog_start);
  cover property ($rose(pin_oe));
  cover property (setup_word[0]);
endmodule // sensor_readout_sva

bind sensor_dsp_readout_diag sensor_readout_sva chk (
  .clk_sys, .rst_b, .pin_in, .pin_out, .pin_oe, .analog_enable, .dac_word,
  .sample_valid, .final_in, .nvm_prog_start, .nvm_prog_index,
  .nvm_prog_done, .setup_word, .offset_coeff_const);

// file: tb/pin_programmer.sv
`timescale 1ns/10ps
// programmer on the shared pin; a pull-up holds a released line high
module pin_programmer (
  input wire clk_sys,
  input wire dev_out,
  input wire dev_oe,
  output wire line
);
  localparam int BIT = 100;
  logic drv = 1'b1;
  logic oe = 1'b0;
  // one pin per device is the only select there is
  assign line = dev_oe ? dev_out : (oe ? drv : 1'b1);
  // start bit, then 24 bits msb first; last bit let go once sampled
  task automatic send(input logic [23:0] f);
    int i;
    @(posedge clk_sys);
    #1 oe = 1'b1;
    drv = 1'b0;
    repeat (BIT) @(posedge clk_sys);
    for (i = 23; i >= 0; i--) begin
      #1 drv = f[i];
      repeat (i == 0 ? 55 : BIT) @(posedge clk_sys);
    end
    #1 oe = 1'b0;
  endtask
  // wait for a reply start bit, then sample each cell in its middle
  task automatic recv(input int n, output logic [15:0] v, output bit ok);
    int k;
    v = 16'h0000;
    ok = 1'b0;
    for (k = 0; k < 400 && line !== 1'b0; k++) @(posedge clk_sys);
    if (line !== 1'b0) return;
    repeat (BIT / 2) @(posedge clk_sys);
    ok = (line === 1'b0);
    repeat (n) begin
      repeat (BIT) @(posedge clk_sys);
      v = {v[14:0], line};
    end
  endtask
endmodule // pin_programmer

// file: tb/sensor_dsp_readout_diag_tb.sv
`timescale 1ns/10ps
module sensor_dsp_readout_diag_tb;
  localparam logic [15:0] INFO_A = 16'h0F1E; // arbitrary value
  localparam logic [15:0] INFO_B = 16'h2D3C; // arbitrary value
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic sample_valid = 1'b0, factory_overflow_in = 1'b0;
  logic fsm_selftest_fail = 1'b0, rom_parity_error = 1'b0;
  logic nvm_selftest_done = 1'b0, nvm_selftest_fail = 1'b0;
  logic nvm_prog_done = 1'b0, nvm_pump_low = 1'b0;
  logic nvm_supply_low = 1'b0, nvm_write_fail = 1'b0;
  logic [7:0] nvm_prog_result = 8'h00;
  logic [21:0] decimated_field_in = 22'h000000;
  logic [15:0] temperature_in = 16'h8000, factory_field_in = 16'h0000;
  logic [15:0] linearized_in = 16'h7FFF, scaled_in = 16'h4321;
  logic [15:0] final_in = 16'hC0DE;
  logic [6:0] si [10] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
    7'h06, 7'h07, 7'h08, 7'h30};
  logic [15:0] se [10] = '{16'h8000, 16'hAAF3, 16'h0000, 16'h0123,
    16'h7FFF, 16'h4321, 16'hC0DE, INFO_A, INFO_B, 16'h0000};
  logic [21:0] fd [2] = '{22'h100000, 22'h2FFFFF};
  logic [15:0] fe [2] = '{16'h7FFF, 16'h8000};
  wire pin_in, pin_out, pin_oe, analog_enable, nvm_prog_start;
  wire [15:0] dac_word, setup_word, gain_coeff_const;
  wire [15:0] offset_coeff_linear, nvm_prog_data;
  int err_count = 0, tests_run = 0, nvm_wait = 0;

  always #50 clk_sys = ~clk_sys;

  sensor_dsp_readout_diag #(.PROD_INFO_A(INFO_A), .PROD_INFO_B(INFO_B)) DUT (
    .clk_sys, .rst_b, .pin_in, .pin_out, .pin_oe, .analog_enable, .dac_word,
    .sample_valid, .temperature_in, .decimated_field_in, .factory_field_in,
    .factory_overflow_in, .linearized_in, .scaled_in, .final_in,
    .fsm_selftest_fail, .nvm_selftest_done, .nvm_selftest_fail,
    .rom_parity_error, .nvm_lock_stored(1'b0), .nvm_prog_start,
    .nvm_prog_index(), .nvm_prog_data, .nvm_prog_done, .nvm_pump_low,
    .nvm_supply_low, .nvm_write_fail, .nvm_prog_result, .setup_word,
    .gain_coeff_const, .gain_coeff_linear(), .gain_coeff_square(),
    .offset_coeff_const(), .offset_coeff_linear);
  pin_programmer prog (.clk_sys, .dev_out(pin_out), .dev_oe(pin_oe),
    .line(pin_in));

  // storage finishes each program request some clocks later
  always @(posedge clk_sys) begin
    #1 nvm_prog_done = (nvm_wait == 1);
    if (nvm_prog_start === 1'b1) nvm_wait = 30;
    else if (nvm_wait > 0) nvm_wait--;
  end

  task automatic check(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // frames sent while the device is busy are dropped, so wait it out
  task automatic wait_idle();
    int k;
    for (k = 0; k < 5000 && !(pin_oe === 1'b0 && analog_enable === 1'b1);
         k++) @(posedge clk_sys);
    check("link idle", 16'h0001, {15'h0000, k < 5000});
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd_chk(input logic [6:0] idx, input logic [15:0] exp);
    logic [15:0] v;
    bit ok;
    prog.send({1'b0, idx, 16'h0000});
    prog.recv(16, v, ok);
    wait_idle();
    check($sformatf("register %h", idx), exp, ok ? v : 16'hxxxx);
  endtask
  // an accepted write answers ack1 then, after storage, ack2; a refused one sends both at once
  task automatic wr_chk(input logic [6:0] idx, input logic [15:0] d,
                        input logic [1:0] exp);
    logic [15:0] v1, v2;
    bit ok1, ok2;
    prog.send({1'b1, idx, d});
    prog.recv(1, v1, ok1);
    prog.recv(1, v2, ok2);
    wait_idle();
    check($sformatf("write ack %h", idx), {14'h0000, exp},
          {14'h0000, ok1 ? v1[0] : 1'bx, ok2 ? v2[0] : 1'bx});
  endtask
  task automatic sample(input logic [21:0] dec, input logic ovf);
    @(posedge clk_sys);
    #1 {sample_valid, factory_overflow_in} = {1'b1, ovf};
    decimated_field_in = dec;
    @(posedge clk_sys);
    #1 {sample_valid, factory_overflow_in} = 2'b00;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    int i;
    repeat (12) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    repeat (5) @(posedge clk_sys);
    rd_chk(7'h10, 16'h1000);
    check("gain const port", 16'h7FFF, gain_coeff_const);
    $display("test reset values done");
    wr_chk(7'h14, 16'h0123, 2'b11);
    wr_chk(7'h02, 16'h5555, 2'b10);
    sample(22'h2ABCDE, 1'b0);
    check("dac word", 16'hC0DE, dac_word);
    for (i = 0; i < 5; i++)
      rd_chk(si[i], se[i]);
    for (i = 5; i < 10; i++)
      rd_chk(si[i], se[i]);
    $display("test snapshots done");
    wr_chk(7'h10, 16'h6000, 2'b11);
    for (i = 0; i < 2; i++) begin
      sample(fd[i], 1'b0);
      rd_chk(7'h01, fe[i]);
    end
    $display("test range window done");
    @(posedge clk_sys);
    #1 {fsm_selftest_fail, rom_parity_error} = 2'b11;
    {nvm_selftest_done, nvm_selftest_fail} = 2'b11;
    @(posedge clk_sys);
    #1 {fsm_selftest_fail, rom_parity_error} = 2'b00;
    {nvm_selftest_done, nvm_selftest_fail} = 2'b00;
    sample(22'h000000, 1'b1);
    rd_chk(7'h09, 16'h003C);
    $display("test self-test flags done");
    {nvm_pump_low, nvm_supply_low, nvm_write_fail} = 3'b111;
    nvm_prog_result = 8'hA5;
    wr_chk(7'h15, 16'h0042, 2'b10);
    rd_chk(7'h0A, 16'h07A5);
    {nvm_pump_low, nvm_supply_low, nvm_write_fail} = 3'b000;
    nvm_prog_result = 8'h3C;
    wr_chk(7'h15, 16'h0042, 2'b11);
    rd_chk(7'h0A, 16'h073C);
    rd_chk(7'h15, 16'h0042);
    check("offset linear port", 16'h0042, offset_coeff_linear);
    check("program data", 16'h0042, nvm_prog_data);
    $display("test programming status done");
    wr_chk(7'h10, 16'h6001, 2'b11);
    wr_chk(7'h11, 16'h1111, 2'b10);
    rd_chk(7'h11, 16'h7FFF);
    check("setup port", 16'h6001, setup_word);
    $display("test lock done");
    complete_run();
  end

  // whole sequence needs just over 95000 clocks
  initial begin
    #10_000_000;
    err_count++;
    complete_run();
  end
endmodule // sensor_dsp_readout_diag_tb
